// ==== shared/mmlq_pkg.sv ====
// Types for the lock, queue status and bus handoff block.
// Assumes the constants header is on the include path.
package mmlq_pkg;
    typedef enum logic [2:0] {
        MMLQ_IDLE,
        MMLQ_PEND,
        MMLQ_GRANT,
        MMLQ_HELD,
        MMLQ_GAP
    } mmlq_rg_t;
endpackage : mmlq_pkg

// ==== shared/mmlq_regs.svh ====
// Timing and encoding constants for the lock, queue status and bus handoff block.
// Assumes inclusion by bare name from the engine and top design files.
`ifndef MMLQ_REGS_SVH
`define MMLQ_REGS_SVH
`define MMLQ_QS_NOP 2'h0
`define MMLQ_QS_FIRST 2'h1
`define MMLQ_QS_FLUSH 2'h2
`define MMLQ_QS_NEXT 2'h3
`define MMLQ_GAP_CYCLES 2'h1
`endif

// ==== shared/mmlq_rg_if.sv ====
// Carrier between the top and the request/grant line engine.
// Assumes a single clock domain.
`timescale 1ns/100ps
interface mmlq_rg_if;
    logic ok_to_yield;
    logic granted;
    logic bus_float;
    modport top (output ok_to_yield, input granted, input bus_float);
    modport eng (input ok_to_yield, output granted, output bus_float);
endinterface : mmlq_rg_if

// ==== src/mmlq_rg_engine.sv ====
// One request/grant line engine: request, grant, release.
// Assumes the line input is already synchronised to core_clk.
`timescale 1ns/100ps
module mmlq_rg_engine
    import mmlq_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic line_in,
    output logic line_out,
    output logic line_oe_n,
    mmlq_rg_if.eng ctl
);
    `include "mmlq_regs.svh"
    mmlq_rg_t state_r, state_nxt;
    logic line_d_r, line_d_nxt;
    // Our own grant pulse comes back through the pad synchroniser; mask it so it is not taken as a release
    logic [1:0] echo_r, echo_nxt;

    // ----------------------------------------
    // Handshake sequencing
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        line_d_nxt = line_in;
        echo_nxt = {echo_r[0], state_r == MMLQ_GRANT};
        case (state_r)
            MMLQ_IDLE: begin
                if (!line_in && line_d_r) begin
                    state_nxt = MMLQ_PEND;
                end
            end
            MMLQ_PEND: begin
                if (ctl.ok_to_yield) begin
                    state_nxt = MMLQ_GRANT;
                end
            end
            MMLQ_GRANT: state_nxt = MMLQ_HELD;
            MMLQ_HELD: begin
                if (!line_in && line_d_r && (echo_r == 2'h0)) begin
                    state_nxt = MMLQ_GAP;
                end
            end
            MMLQ_GAP: state_nxt = MMLQ_IDLE;
            default: state_nxt = MMLQ_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= MMLQ_IDLE;
            line_d_r <= 1'b1;
            echo_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            line_d_r <= line_d_nxt;
            echo_r <= echo_nxt;
        end
    end

    // Drive low only for the grant clock; otherwise the line floats
    assign line_out = 1'b0;
    assign line_oe_n = (state_r != MMLQ_GRANT);
    assign ctl.granted = (state_r == MMLQ_GRANT) || (state_r == MMLQ_HELD);
    assign ctl.bus_float = ctl.granted;
endmodule : mmlq_rg_engine

// ==== src/mmlq_top.sv ====
// Maximum-mode lock, queue status and request/grant handoff logic.
// Assumes the core supplies one-cycle event strobes on core_clk,
// and that the line pads add the weak pull-up that holds idle lines high.
`timescale 1ns/100ps
module mmlq_top
    import mmlq_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic lock_prefix,
    input wire logic instr_done,
    input wire logic int_ack_cycle,
    input wire logic int_ack_second,
    input wire logic t2_state,
    input wire logic t4_or_idle,
    input wire logic odd_word_low,
    input wire logic q_first,
    input wire logic q_next,
    input wire logic q_flush,
    input wire logic req_grant_line_a_in,
    output logic req_grant_line_a_out,
    output logic req_grant_line_a_oe_n,
    input wire logic req_grant_line_b_in,
    output logic req_grant_line_b_out,
    output logic req_grant_line_b_oe_n,
    output logic lock_n_out,
    output logic lock_n_oe_n,
    output logic queue_state_hi,
    output logic queue_state_lo,
    output logic bus_float,
    output logic bus_grant_a,
    output logic bus_grant_b
);
    `include "mmlq_regs.svh"

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] sa_r, sa_nxt, sb_r, sb_nxt;
    always_comb begin
        sa_nxt = {sa_r[0], req_grant_line_a_in};
        sb_nxt = {sb_r[0], req_grant_line_b_in};
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sa_r <= 2'h3;
            sb_r <= 2'h3;
        end else begin
            sa_r <= sa_nxt;
            sb_r <= sb_nxt;
        end
    end

    // ----------------------------------------
    // Lock output
    // ----------------------------------------
    logic pfx_lock_r, pfx_lock_nxt, ack_lock_r, ack_lock_nxt, pend_done_r, pend_done_nxt;
    logic lock_n_r, lock_n_nxt;
    mmlq_rg_if ifa ();
    mmlq_rg_if ifb ();
    logic any_float;
    assign any_float = ifa.bus_float || ifb.bus_float;

    always_comb begin
        pfx_lock_nxt = pfx_lock_r;
        pend_done_nxt = pend_done_r;
        ack_lock_nxt = ack_lock_r;
        // Prefix arms; first done ends prefix, second done ends locked instruction
        if (lock_prefix) begin
            pfx_lock_nxt = 1'b1;
            pend_done_nxt = 1'b1;
        end else if (instr_done && pfx_lock_r) begin
            if (pend_done_r) begin
                pend_done_nxt = 1'b0;
            end else begin
                pfx_lock_nxt = 1'b0;
            end
        end
        if (int_ack_cycle && t2_state) begin
            ack_lock_nxt = !int_ack_second;
        end
        lock_n_nxt = !(pfx_lock_nxt || ack_lock_nxt);
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pfx_lock_r <= 1'b0;
            pend_done_r <= 1'b0;
            ack_lock_r <= 1'b0;
            lock_n_r <= 1'b1;
        end else begin
            pfx_lock_r <= pfx_lock_nxt;
            pend_done_r <= pend_done_nxt;
            ack_lock_r <= ack_lock_nxt;
            lock_n_r <= lock_n_nxt;
        end
    end
    assign lock_n_out = lock_n_r;
    // Released to the pad while the other master owns the bus; pull-up gives a one
    assign lock_n_oe_n = any_float;

    // ----------------------------------------
    // Queue status
    // ----------------------------------------
    logic [1:0] qs_r, qs_nxt;
    always_comb begin
        if (q_flush) begin
            qs_nxt = `MMLQ_QS_FLUSH;
        end else if (q_first) begin
            qs_nxt = `MMLQ_QS_FIRST;
        end else if (q_next) begin
            qs_nxt = `MMLQ_QS_NEXT;
        end else begin
            qs_nxt = `MMLQ_QS_NOP;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            qs_r <= `MMLQ_QS_NOP;
        end else begin
            qs_r <= qs_nxt;
        end
    end
    // Plain outputs, no enable: never floated
    assign queue_state_hi = qs_r[1];
    assign queue_state_lo = qs_r[0];

    // ----------------------------------------
    // Yield conditions
    // ----------------------------------------
    logic yield_ok;
    logic ifa_pend;
    // Line a outranks line b; b waits while a's request is low on the line or a is granted or held
    always_comb begin
        yield_ok = t4_or_idle && !odd_word_low
            && !(int_ack_cycle && !int_ack_second) && !pfx_lock_r;
    end
    assign ifa.ok_to_yield = yield_ok && !ifb.granted;
    assign ifb.ok_to_yield = yield_ok && !ifa.granted && !ifa_pend;
    assign ifa_pend = !sa_r[1] && !ifa.granted;

    mmlq_rg_engine u_eng_a (
        .core_clk(core_clk),
        .rst(rst),
        .line_in(sa_r[1]),
        .line_out(req_grant_line_a_out),
        .line_oe_n(req_grant_line_a_oe_n),
        .ctl(ifa.eng)
    );
    mmlq_rg_engine u_eng_b (
        .core_clk(core_clk),
        .rst(rst),
        .line_in(sb_r[1]),
        .line_out(req_grant_line_b_out),
        .line_oe_n(req_grant_line_b_oe_n),
        .ctl(ifb.eng)
    );
    assign bus_float = any_float;
    assign bus_grant_a = ifa.granted;
    assign bus_grant_b = ifb.granted;
endmodule : mmlq_top

// ==== tb/mmlq_assertions.sv ====
// Checker for lock, queue status and grant outputs.
// Assumes it is bound to mmlq_top.
`timescale 1ns/100ps
module mmlq_assertions (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic lock_prefix,
    input wire logic int_ack_cycle,
    input wire logic int_ack_second,
    input wire logic t2_state,
    input wire logic q_first,
    input wire logic q_next,
    input wire logic q_flush,
    input wire logic req_grant_line_a_out,
    input wire logic req_grant_line_a_oe_n,
    input wire logic lock_n_out,
    input wire logic lock_n_oe_n,
    input wire logic queue_state_hi,
    input wire logic queue_state_lo,
    input wire logic bus_float,
    input wire logic bus_grant_a,
    input wire logic bus_grant_b
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire [1:0] qs = {queue_state_hi, queue_state_lo};
    a_qs_flush: assert property (q_flush |=> qs == 2'h2) else $error("flush code");
    a_qs_first: assert property (q_first && !q_flush |=> qs == 2'h1) else $error("first code");
    a_qs_next: assert property (q_next && !q_first && !q_flush |=> qs == 2'h3) else $error("next code");
    a_qs_idle: assert property (!(q_first | q_next | q_flush) |=> qs == 2'h0) else $error("idle code");
    a_lock_float: assert property (bus_grant_a | bus_grant_b |-> lock_n_oe_n) else $error("lock driven");
    a_grant_one: assert property ($fell(req_grant_line_a_oe_n) |-> bus_float ##1 req_grant_line_a_oe_n)
        else $error("grant pulse");
    a_grant_low: assert property (!req_grant_line_a_oe_n |-> !req_grant_line_a_out) else $error("pulse level");
    a_held_float: assert property (bus_grant_a |-> bus_float) else $error("bus not floated");
    a_lock_prefix: assert property (lock_prefix && !bus_float |=> !lock_n_out) else $error("lock late");
    a_lock_int_ack_cycle: assert property (int_ack_cycle && !int_ack_second && t2_state |=> !lock_n_out)
        else $error("ack lock");
endmodule : mmlq_assertions
bind mmlq_top mmlq_assertions u_chk (.*);

// ==== tb/mmlq_partner.sv ====
// External bus master on one request/grant line.
// Assumes the bench resolves the line with a pull-up.
`timescale 1ns/100ps
module mmlq_partner (
    input wire logic core_clk,
    input wire logic line,
    output logic drive_n
);
    logic seen;
    initial begin
        drive_n = 1'b1;
        seen = 1'b0;
    end
    task automatic exchange(input int hold);
        int n;
        seen = 1'b0;
        @(posedge core_clk);
        #1 drive_n = 1'b0; // One-clock low request
        @(posedge core_clk);
        #1 drive_n = 1'b1;
        for (n = 0; n < 40 && !seen; n++) begin
            @(posedge core_clk);
            seen = (line === 1'b0); // Second pulse is the grant
        end
        repeat (hold) @(posedge core_clk);
        #1 drive_n = !seen; // Release only what was granted
        @(posedge core_clk);
        #1 drive_n = 1'b1;
        repeat (2) @(posedge core_clk); // Idle gap before reuse
    endtask : exchange
endmodule : mmlq_partner

// ==== tb/testbench.sv ====
// Self-checking bench for mmlq_top.
// Assumes mmlq_partner drives the far side of both lines.
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
    logic core_clk = 0, rst = 1, lock_prefix = 0, instr_done = 0, int_ack_cycle = 0, int_ack_second = 0;
    logic t2_state = 0, t4_or_idle = 0, odd_word_low = 0, q_first = 0, q_next = 0, q_flush = 0;
    logic req_grant_line_a_out, req_grant_line_a_oe_n, req_grant_line_b_out, req_grant_line_b_oe_n;
    logic lock_n_out, lock_n_oe_n, queue_state_hi, queue_state_lo, bus_float, bus_grant_a, bus_grant_b;
    wire drv_a_n, drv_b_n;
    // Pull-up wins unless a party drives low
    wire req_grant_line_a_in = (req_grant_line_a_oe_n | req_grant_line_a_out) & drv_a_n;
    wire req_grant_line_b_in = (req_grant_line_b_oe_n | req_grant_line_b_out) & drv_b_n;
    int bad_count = 0, samples_checked = 0;
    logic [1:0] exp_q[$];
    always #20 core_clk = ~core_clk;
    mmlq_top u_mmlq_top (.*);
    mmlq_partner u_partner_a (.core_clk(core_clk), .line(req_grant_line_a_in), .drive_n(drv_a_n));
    mmlq_partner u_partner_b (.core_clk(core_clk), .line(req_grant_line_b_in), .drive_n(drv_b_n));
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask : step
    task automatic instr_end();
        instr_done = 1;
        step();
        instr_done = 0;
    endtask : instr_end
    task automatic end_of_test();
        $display("Checks %0d, errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    initial begin
        void'($urandom(32'h0271EFEC));
        repeat (5) @(posedge core_clk);
        #1 rst = 0;
        exp_q.push_back(2'h0);
        repeat (200) begin
            step();
            `CHK({queue_state_hi, queue_state_lo}, exp_q.pop_front())
            {q_flush, q_first, q_next} = 3'($urandom);
            exp_q.push_back(q_flush ? 2'h2 : q_first ? 2'h1 : q_next ? 2'h3 : 2'h0);
        end
        {q_flush, q_first, q_next} = 3'h0;
        lock_prefix = 1;
        step();
        lock_prefix = 0;
        `CHK(lock_n_out, 1'b0)
        instr_end();
        `CHK(lock_n_out, 1'b0)
        instr_end();
        `CHK(lock_n_out, 1'b1)
        int_ack_cycle = 1;
        t2_state = 1;
        step();
        t2_state = 0;
        `CHK(lock_n_out, 1'b0)
        repeat (2) step();
        int_ack_second = 1;
        t2_state = 1;
        step();
        {t2_state, int_ack_cycle, int_ack_second} = 3'h0;
        `CHK(lock_n_out, 1'b1)
        t4_or_idle = 1;
        fork
            u_partner_a.exchange(6);
            begin
                repeat (9) step();
                `CHK({bus_float, bus_grant_a, lock_n_oe_n}, 3'h7)
                `CHK({queue_state_hi, queue_state_lo}, 2'h0)
            end
        join
        step();
        `CHK({u_partner_a.seen, bus_float}, 2'h2)
        odd_word_low = 1;
        fork
            u_partner_b.exchange(2);
            begin
                repeat (12) step();
                `CHK(u_partner_b.seen, 1'b0)
                `CHK(bus_grant_b, 1'b0)
                odd_word_low = 0;
            end
        join
        `CHK(u_partner_b.seen, 1'b1)
        #1;
        lock_prefix = 1;
        step();
        lock_prefix = 0;
        fork
            u_partner_a.exchange(2);
            begin
                repeat (12) step();
                `CHK(u_partner_a.seen, 1'b0)
                instr_end();
                instr_end();
            end
        join
        `CHK(u_partner_a.seen, 1'b1)
        end_of_test();
    end
    initial begin
        #400000;
        bad_count++;
        end_of_test();
    end
endmodule : testbench
